// ---- adsq_ctrl.sv ----
// Purpose: Four-sequencer control of a 10-bit converter with result queues
// Assumes: Converter handshake and triggers are asynchronous to clk_sys
// Notes: Registers answer reads one cycle after the read strobe

`timescale 1ns/10ps

module adsq_ctrl
  import adsq_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata_r,
  input wire adsq_trig_t trig_in,
  input wire logic conv_done,
  input wire logic [RES_W-1:0] conv_result,
  output adsq_conv_t conv_req_r,
  output logic irq_r
);
  // ****************************************
  // State
  // ****************************************
  logic [NSEQ-1:0] run_r;
  logic [NSEQ-1:0] raw_r;
  logic [NSEQ-1:0] mask_r;
  logic [NSEQ-1:0] ovf_r;
  logic [NSEQ-1:0] unf_r;
  logic [NSEQ-1:0] pend_r;
  logic [15:0] emux_r;
  logic [15:0] pri_r;
  logic [2:0] sac_r;
  logic [31:0] mux_r [NSEQ];
  logic [31:0] ctl_r [NSEQ];
  adsq_state_t st_r;
  logic [1:0] cur_r;
  logic [2:0] step_r;
  logic [5:0] avg_cnt_r;
  logic [ACC_W-1:0] acc_r;
  logic [2:0] div_r;
  adsq_trig_t trig_s1_r;
  adsq_trig_t trig_s2_r;
  adsq_trig_t trig_s3_r;
  logic done_s1_r;
  logic done_s2_r;
  logic done_s3_r;
  logic [RES_W-1:0] res_s1_r;
  logic [RES_W-1:0] res_s2_r;

  logic tick;
  logic done_rise;
  adsq_trig_t trig_rise;
  logic [NSEQ-1:0] trig_hit;
  logic [NSEQ-1:0] take;
  logic grant_v;
  logic [1:0] grant_idx;
  logic [3:0] mux_nib;
  logic [3:0] ctl_nib;
  logic last_v;
  logic [2:0] sac_eff;
  logic avg_last;
  logic [NSEQ-1:0] push;
  logic [NSEQ-1:0] pop;
  logic [RES_W-1:0] head_data [NSEQ];
  logic [3:0] wr_ptr [NSEQ];
  logic [3:0] rd_ptr [NSEQ];
  logic [NSEQ-1:0] q_full;
  logic [NSEQ-1:0] q_empty;
  logic [NSEQ-1:0] q_ovf;
  logic [NSEQ-1:0] q_unf;
  logic [NSEQ-1:0] ie_set;
  logic wr_isc;
  logic rd_isc;

  function automatic logic [11:0] ss_addr(input int n, input logic [11:0] ofs);
    ss_addr = 12'(OFS_SS_BASE + n * OFS_SS_STEP + ofs);
  endfunction

  // ****************************************
  // Synchronisers and pacing
  // ****************************************
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      trig_s1_r <= '0;
      trig_s2_r <= '0;
      trig_s3_r <= '0;
      done_s1_r <= 1'b0;
      done_s2_r <= 1'b0;
      done_s3_r <= 1'b0;
      res_s1_r <= '0;
      res_s2_r <= '0;
    end
    else if (ce)
    begin
      trig_s1_r <= trig_in;
      trig_s2_r <= trig_s1_r;
      trig_s3_r <= trig_s2_r;
      done_s1_r <= conv_done;
      done_s2_r <= done_s1_r;
      done_s3_r <= done_s2_r;
      res_s1_r <= conv_result;
      res_s2_r <= res_s1_r;
    end
  end

  assign trig_rise = trig_s2_r & ~trig_s3_r;
  assign done_rise = done_s2_r && !done_s3_r;

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      div_r <= '0;
    end
    else if (ce)
    begin
      div_r <= (div_r == ADC_DIV_LAST) ? '0 : div_r + 1'b1;
    end
  end

  assign tick = (div_r == '0);

  // ****************************************
  // Register writes
  // ****************************************
  assign wr_isc = reg_wr && (reg_addr == OFS_ISC);
  assign rd_isc = reg_rd && (reg_addr == OFS_ISC);

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      run_r <= '0;
      mask_r <= '0;
      emux_r <= '0;
      pri_r <= RST_PRI;
      sac_r <= '0;
      for (int n = 0; n < NSEQ; n++)
      begin
        mux_r[n] <= '0;
        ctl_r[n] <= '0;
      end
    end
    else if (ce && reg_wr)
    begin
      unique case (reg_addr)
        OFS_RUN: run_r <= reg_wdata[NSEQ-1:0];
        OFS_IM: mask_r <= reg_wdata[NSEQ-1:0];
        OFS_EMUX: emux_r <= reg_wdata[15:0];
        OFS_PRI: pri_r <= reg_wdata[15:0];
        OFS_SAC: sac_r <= reg_wdata[2:0];
        default:
        begin
        end
      endcase
      for (int n = 0; n < NSEQ; n++)
      begin
        if (reg_addr == ss_addr(n, OFS_SS_MUX))
        begin
          mux_r[n] <= reg_wdata;
        end
        if (reg_addr == ss_addr(n, OFS_SS_CTL))
        begin
          ctl_r[n] <= reg_wdata;
        end
      end
    end
  end

  // ****************************************
  // Status flags, set wins over clear
  // ****************************************
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      raw_r <= '0;
      ovf_r <= '0;
      unf_r <= '0;
      irq_r <= 1'b0;
    end
    else if (ce)
    begin
      raw_r <= (raw_r & ~(wr_isc ? reg_wdata[NSEQ-1:0] : '0)) | ie_set;
      ovf_r <= (ovf_r & ~((reg_wr && reg_addr == OFS_OSTAT) ? reg_wdata[NSEQ-1:0] : '0))
        | q_ovf;
      unf_r <= (unf_r & ~((reg_wr && reg_addr == OFS_USTAT) ? reg_wdata[NSEQ-1:0] : '0))
        | q_unf;
      irq_r <= |(raw_r & mask_r);
    end
  end

  // ****************************************
  // Triggers and arbitration
  // ****************************************
  always_comb
  begin
    trig_hit = '0;
    for (int n = 0; n < NSEQ; n++)
    begin
      unique case (emux_r[n*NIB +: NIB])
        TRG_SW: trig_hit[n] = reg_wr && (reg_addr == OFS_PSSI) && reg_wdata[n];
        TRG_CMP0: trig_hit[n] = trig_rise.cmp[0];
        TRG_CMP1: trig_hit[n] = trig_rise.cmp[1];
        TRG_CMP2: trig_hit[n] = trig_rise.cmp[2];
        TRG_GPIO: trig_hit[n] = trig_rise.gpio;
        TRG_TIMER: trig_hit[n] = trig_rise.timer;
        TRG_ALWAYS: trig_hit[n] = 1'b1;
        default: trig_hit[n] = 1'b0;
      endcase
    end
  end

  always_comb
  begin
    grant_v = 1'b0;
    grant_idx = '0;
    for (int n = 0; n < NSEQ; n++)
    begin
      if (pend_r[n] && run_r[n] && (!grant_v
          || pri_r[n*NIB +: PRI_W] < pri_r[grant_idx*NIB +: PRI_W]))
      begin
        grant_v = 1'b1;
        grant_idx = 2'(n);
      end
    end
  end

  assign take = (st_r == ST_IDLE && grant_v) ? NSEQ'(1) << grant_idx : '0;

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pend_r <= '0;
    end
    else if (ce)
    begin
      pend_r <= ((pend_r & ~take) | (trig_hit & run_r)) & run_r;
    end
  end

  // ****************************************
  // Step sequencing and averaging
  // ****************************************
  assign mux_nib = mux_r[cur_r][step_r*NIB +: NIB];
  assign ctl_nib = ctl_r[cur_r][step_r*NIB +: NIB];
  assign last_v = ctl_nib[CTL_END] || (step_r == 3'(SEQ_DEPTH[cur_r] - 1));
  assign sac_eff = (sac_r > SAC_MAX) ? SAC_MAX : sac_r;
  assign avg_last = (avg_cnt_r == 6'((7'd1 << sac_eff) - 7'd1));
  assign push = (st_r == ST_STORE) ? NSEQ'(1) << cur_r : '0;
  assign ie_set = (st_r == ST_STORE && ctl_nib[CTL_IE]) ? push : '0;

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_r <= ST_IDLE;
      cur_r <= '0;
      step_r <= '0;
      avg_cnt_r <= '0;
      acc_r <= '0;
      conv_req_r <= '0;
    end
    else if (ce)
    begin
      conv_req_r.start <= 1'b0;
      unique case (st_r)
        ST_IDLE:
        begin
          if (grant_v)
          begin
            cur_r <= grant_idx;
            step_r <= '0;
            avg_cnt_r <= '0;
            acc_r <= '0;
            st_r <= ST_START;
          end
        end
        ST_START:
        begin
          if (tick)
          begin
            conv_req_r.start <= 1'b1;
            conv_req_r.diff <= ctl_nib[CTL_DIFF];
            conv_req_r.temp <= ctl_nib[CTL_TEMP];
            conv_req_r.pos <= ctl_nib[CTL_DIFF] ? {mux_nib[2:0], 1'b0} : mux_nib;
            conv_req_r.neg <= ctl_nib[CTL_DIFF] ? {mux_nib[2:0], 1'b1} : '0;
            st_r <= ST_WAIT;
          end
        end
        ST_WAIT:
        begin
          if (done_rise)
          begin
            acc_r <= acc_r + ACC_W'(res_s2_r);
            avg_cnt_r <= avg_cnt_r + 1'b1;
            st_r <= avg_last ? ST_STORE : ST_START;
          end
        end
        ST_STORE:
        begin
          acc_r <= '0;
          avg_cnt_r <= '0;
          step_r <= step_r + 1'b1;
          st_r <= last_v ? ST_IDLE : ST_START;
        end
      endcase
    end
  end

  // ****************************************
  // Result queues
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < NSEQ; g++)
    begin : gen_q
      assign pop[g] = ce && reg_rd && (reg_addr == ss_addr(g, OFS_SS_FIFO));

      adsq_result_fifo #(
        .DEPTH(SEQ_DEPTH[g])
      ) u_fifo (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .ce(ce),
        .push(push[g]),
        .push_data(RES_W'(acc_r >> sac_eff)),
        .pop(pop[g]),
        .head_data(head_data[g]),
        .wr_ptr(wr_ptr[g]),
        .rd_ptr(rd_ptr[g]),
        .full(q_full[g]),
        .empty(q_empty[g]),
        .overflow(q_ovf[g]),
        .underflow(q_unf[g])
      );
    end
  endgenerate

  // ****************************************
  // Register reads
  // ****************************************
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      reg_rdata_r <= '0;
    end
    else if (ce && reg_rd)
    begin
      reg_rdata_r <= '0;
      unique case (reg_addr)
        OFS_RUN: reg_rdata_r[NSEQ-1:0] <= run_r;
        OFS_RIS: reg_rdata_r[NSEQ-1:0] <= raw_r;
        OFS_IM: reg_rdata_r[NSEQ-1:0] <= mask_r;
        OFS_ISC: reg_rdata_r[NSEQ-1:0] <= raw_r & mask_r;
        OFS_OSTAT: reg_rdata_r[NSEQ-1:0] <= ovf_r;
        OFS_EMUX: reg_rdata_r[15:0] <= emux_r;
        OFS_USTAT: reg_rdata_r[NSEQ-1:0] <= unf_r;
        OFS_PRI: reg_rdata_r[15:0] <= pri_r;
        OFS_SAC: reg_rdata_r[2:0] <= sac_r;
        default:
        begin
        end
      endcase
      for (int n = 0; n < NSEQ; n++)
      begin
        if (reg_addr == ss_addr(n, OFS_SS_MUX))
          reg_rdata_r <= mux_r[n];
        if (reg_addr == ss_addr(n, OFS_SS_CTL))
          reg_rdata_r <= ctl_r[n];
        if (reg_addr == ss_addr(n, OFS_SS_FIFO))
          reg_rdata_r <= {22'h000000, head_data[n]};
        if (reg_addr == ss_addr(n, OFS_SS_FSTAT))
        begin
          reg_rdata_r <= '0;
          reg_rdata_r[FST_TAIL +: 4] <= rd_ptr[n];
          reg_rdata_r[FST_HEAD +: 4] <= wr_ptr[n];
          reg_rdata_r[FST_EMPTY] <= q_empty[n];
          reg_rdata_r[FST_FULL] <= q_full[n];
        end
      end
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  sequence s_conv_issue;
    st_r == ST_START && tick && ce;
  endsequence

  sequence s_conv_pulse;
    conv_req_r.start ##1 !conv_req_r.start;
  endsequence

  a_irq_follows_mask: assert property (ce |=> irq_r == |($past(raw_r) & $past(mask_r)))
    else $error("interrupt output not raw AND mask");
  a_isc_read_and: assert property (ce && rd_isc |=> reg_rdata_r[NSEQ-1:0]
    == ($past(raw_r) & $past(mask_r)))
    else $error("masked status read wrong");
  a_isc_clear_one: assert property (ce && wr_isc && reg_wdata[0] && !ie_set[0] |=> !raw_r[0])
    else $error("write one did not clear status");
  a_raw_set_wins: assert property (ce && ie_set[1] |=> raw_r[1])
    else $error("step event lost");
  a_grant_runs: assert property (st_r == ST_IDLE && grant_v |-> run_r[grant_idx])
    else $error("stopped sequencer granted");
  a_grant_prio_best: assert property (st_r == ST_IDLE && grant_v && pend_r[0] && run_r[0]
    |-> pri_r[grant_idx*NIB +: PRI_W] <= pri_r[PRI_W-1:0])
    else $error("lower priority sequencer served first");
  a_conv_pulse_one: assert property (s_conv_issue |=> s_conv_pulse)
    else $error("conversion start not a one-cycle pulse");
  a_end_stops_seq: assert property (st_r == ST_STORE && ce && last_v |=> st_r == ST_IDLE)
    else $error("sequence did not stop at end step");
  a_sw_start_pend: assert property (ce && reg_wr && reg_addr == OFS_PSSI && reg_wdata[2]
    && emux_r[2*NIB +: NIB] == TRG_SW && run_r[2] && !(reg_addr == OFS_RUN)
    |=> pend_r[2])
    else $error("software start ignored");
endmodule

// ---- adsq_pkg.sv ----
// Purpose: Shared constants and types of the converter sequencer control
// Assumes: 125 MHz system clock, 12-bit register byte address
// Notes: Register offsets are byte addresses

package adsq_pkg;
  localparam int NSEQ = 4;
  localparam int RES_W = 10;
  localparam int ACC_W = 16;
  localparam int NIB = 4;
  localparam int PRI_W = 2;
  localparam int SEQ_DEPTH [NSEQ] = '{8, 4, 4, 1};

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [11:0] OFS_RUN = 12'h000;
  localparam logic [11:0] OFS_RIS = 12'h004;
  localparam logic [11:0] OFS_IM = 12'h008;
  localparam logic [11:0] OFS_ISC = 12'h00C;
  localparam logic [11:0] OFS_OSTAT = 12'h010;
  localparam logic [11:0] OFS_EMUX = 12'h014;
  localparam logic [11:0] OFS_USTAT = 12'h018;
  localparam logic [11:0] OFS_PRI = 12'h020;
  localparam logic [11:0] OFS_PSSI = 12'h028;
  localparam logic [11:0] OFS_SAC = 12'h030;
  localparam logic [11:0] OFS_SS_BASE = 12'h040;
  localparam logic [11:0] OFS_SS_STEP = 12'h020;
  localparam logic [11:0] OFS_SS_MUX = 12'h000;
  localparam logic [11:0] OFS_SS_CTL = 12'h004;
  localparam logic [11:0] OFS_SS_FIFO = 12'h008;
  localparam logic [11:0] OFS_SS_FSTAT = 12'h00C;
  localparam logic [15:0] RST_PRI = 16'h3210;
  localparam logic [2:0] SAC_MAX = 3'h6;

  // ****************************************
  // Field positions and codes
  // ****************************************
  localparam int CTL_DIFF = 0;
  localparam int CTL_END = 1;
  localparam int CTL_IE = 2;
  localparam int CTL_TEMP = 3;
  localparam int FST_TAIL = 0;
  localparam int FST_HEAD = 4;
  localparam int FST_EMPTY = 8;
  localparam int FST_FULL = 12;
  localparam logic [3:0] TRG_SW = 4'h0;
  localparam logic [3:0] TRG_CMP0 = 4'h1;
  localparam logic [3:0] TRG_CMP1 = 4'h2;
  localparam logic [3:0] TRG_CMP2 = 4'h3;
  localparam logic [3:0] TRG_GPIO = 4'h4;
  localparam logic [3:0] TRG_TIMER = 4'h5;
  localparam logic [3:0] TRG_ALWAYS = 4'hF;

  // ****************************************
  // Timing
  // ****************************************
  localparam int SYS_CLK_KHZ = 125000;
  localparam int ADC_TGT_KHZ = 16667;
  localparam int ADC_DIV = (SYS_CLK_KHZ + ADC_TGT_KHZ - 1) / ADC_TGT_KHZ;
  localparam logic [2:0] ADC_DIV_LAST = 3'(ADC_DIV - 1);

  typedef struct packed {
    logic [2:0] cmp;
    logic gpio;
    logic timer;
  } adsq_trig_t;

  typedef struct packed {
    logic start;
    logic diff;
    logic temp;
    logic [3:0] pos;
    logic [3:0] neg;
  } adsq_conv_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_START = 2'b01,
    ST_WAIT = 2'b11,
    ST_STORE = 2'b10
  } adsq_state_t;
endpackage

// ---- adsq_result_fifo.sv ----
// Purpose: Circular result queue of one sequencer
// Assumes: Push and pop come from logic on clk_sys
// Notes: Push when full is dropped, pop when empty returns stale data

`timescale 1ns/10ps

module adsq_result_fifo
  import adsq_pkg::*;
#(
  parameter int DEPTH = 8
)
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic push,
  input wire logic [RES_W-1:0] push_data,
  input wire logic pop,
  output logic [RES_W-1:0] head_data,
  output logic [3:0] wr_ptr,
  output logic [3:0] rd_ptr,
  output logic full,
  output logic empty,
  output logic overflow,
  output logic underflow
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  localparam logic [AW:0] CNT_FULL = (AW + 1)'(DEPTH);

  logic [RES_W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] cnt_r;
  logic do_push;
  logic do_pop;

  assign full = (cnt_r == CNT_FULL);
  assign empty = (cnt_r == '0);
  assign do_push = push && !full;
  assign do_pop = pop && !empty;
  assign overflow = push && full;
  assign underflow = pop && empty;
  assign head_data = mem[rd_ptr_r];
  assign wr_ptr = 4'(wr_ptr_r);
  assign rd_ptr = 4'(rd_ptr_r);

  always_ff @(posedge clk_sys)
  begin
    if (ce && do_push)
    begin
      mem[wr_ptr_r] <= push_data;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r <= '0;
    end
    else if (ce)
    begin
      if (do_push)
      begin
        wr_ptr_r <= (wr_ptr_r == LAST) ? '0 : wr_ptr_r + 1'b1;
      end
      if (do_pop)
      begin
        rd_ptr_r <= (rd_ptr_r == LAST) ? '0 : rd_ptr_r + 1'b1;
      end
      if (do_push && !do_pop)
      begin
        cnt_r <= cnt_r + 1'b1;
      end
      else if (do_pop && !do_push)
      begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end
endmodule

// ---- adsq_conv_model.sv ----
// Purpose: Behavioural converter on the far side of the sequencer control
// Assumes: Start pulses arrive one at a time
// Notes: Result encodes the request so the bench can predict it

`timescale 1ns/10ps

module adsq_conv_model
  import adsq_pkg::*;
(
  input wire logic clk_sys,
  input wire logic slow,
  input wire adsq_conv_t req,
  output logic done,
  output logic [RES_W-1:0] result
);
  int ph = 0;

  initial
  begin
    done = 1'b0;
    result = 10'h2AA;
  end

  // Done high for five cycles, result held until done falls, then toggling
  always @(posedge clk_sys)
  begin
    if (req.start === 1'b1)
    begin
      ph <= slow ? 20 : 8;
      result <= {req.pos, req.neg, req.diff, req.temp};
    end
    else if (ph > 0)
      ph <= ph - 1;
    else
      result <= ~result;
    done <= (ph > 0) && (ph <= 5);
  end
endmodule

// ---- adsq_ctrl_test.sv ----
// Purpose: Self-checking bench of the sequencer control
// Assumes: Converter model answers every start
// Notes: Verdict printed by summarize

`timescale 1ns/10ps

module adsq_ctrl_test;
  import adsq_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic ce = 1'b1;
  logic [11:0] reg_addr = 12'h000;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata_r;
  adsq_trig_t trig_in = '0;
  logic conv_done;
  logic [RES_W-1:0] conv_result;
  adsq_conv_t conv_req_r;
  logic irq_r;
  logic slow = 1'b0;
  int n_fail = 0;
  int samples_checked = 0;
  int cyc = 0;
  logic [3:0] pos_log[$];
  logic [31:0] v;

  always #4 clk_sys = ~clk_sys;

  adsq_ctrl dut (.clk_sys(clk_sys), .rst_b(rst_b), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r),
    .trig_in(trig_in), .conv_done(conv_done), .conv_result(conv_result),
    .conv_req_r(conv_req_r), .irq_r(irq_r));

  adsq_conv_model conv (.clk_sys(clk_sys), .slow(slow), .req(conv_req_r),
    .done(conv_done), .result(conv_result));

  // ****************************************
  // Monitor and timeout
  // ****************************************
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (conv_req_r.start === 1'b1)
      pos_log.push_back(conv_req_r.pos);
    if (cyc == 30000)
    begin
      n_fail = n_fail + 1;
      summarize();
    end
  end

  task automatic summarize();
    if (n_fail == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      n_fail++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 v = reg_rdata_r;
  endtask

  task automatic rc(input logic [11:0] a, input logic [31:0] e, input string nm);
    rd(a);
    chk(nm, e, v);
  endtask

  task automatic poll(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    for (int i = 0; i < 300; i++)
    begin
      rd(a);
      if ((v & m) === e)
        break;
    end
    chk("poll", e, v & m);
  endtask

  function automatic logic [11:0] ss(input int n, input logic [11:0] o);
    ss = OFS_SS_BASE + 12'(n) * OFS_SS_STEP + o;
  endfunction

  function automatic logic [31:0] code(input logic [3:0] nib, input logic diff);
    code = diff ? {22'h0, nib[2:0], 1'b0, nib[2:0], 1'b1, 1'b1, 1'b0}
      : {22'h0, nib, 4'h0, 2'b00};
  endfunction

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_seq0();
    int n0;
    wr(ss(0, OFS_SS_MUX), 32'h0000_0355);
    wr(ss(0, OFS_SS_CTL), 32'h0000_0604);
    rc(ss(0, OFS_SS_CTL), 32'h0000_0604, "ctl0");
    wr(OFS_IM, 32'h1);
    wr(OFS_PSSI, 32'h1);
    rc(ss(0, OFS_SS_FSTAT), 32'h100, "idle0");
    n0 = pos_log.size();
    wr(OFS_RUN, 32'h1);
    wr(OFS_PSSI, 32'h1);
    poll(ss(0, OFS_SS_FSTAT), 32'hF0, 32'h30);
    rc(ss(0, OFS_SS_FSTAT), 32'h030, "fst0");
    rc(OFS_ISC, 32'h1, "isc0");
    chk("irq", 32'h1, {31'h0, irq_r});
    rc(ss(0, OFS_SS_FIFO), code(4'h5, 1'b0), "q0");
    rc(ss(0, OFS_SS_FIFO), code(4'h5, 1'b0), "q1");
    rc(ss(0, OFS_SS_FIFO), code(4'h3, 1'b0), "q2");
    rc(ss(0, OFS_SS_FSTAT), 32'h133, "fst1");
    wr(OFS_ISC, 32'h0);
    rc(OFS_RIS, 32'h1, "ris0");
    wr(OFS_ISC, 32'h1);
    rc(OFS_RIS, 32'h0, "ris1");
    chk("irq", 32'h0, {31'h0, irq_r});
    chk("nconv", 32'h3, 32'(pos_log.size() - n0));
  endtask

  task automatic t_avg();
    int n0;
    n0 = pos_log.size();
    wr(OFS_IM, 32'h0);
    wr(OFS_SAC, 32'h2);
    wr(ss(1, OFS_SS_MUX), 32'h1);
    wr(ss(1, OFS_SS_CTL), 32'h7);
    wr(OFS_RUN, 32'h2);
    slow <= 1'b1;
    wr(OFS_PSSI, 32'h2);
    poll(OFS_RIS, 32'h2, 32'h2);
    rc(OFS_ISC, 32'h0, "isc1");
    chk("irq", 32'h0, {31'h0, irq_r});
    chk("navg", 32'h4, 32'(pos_log.size() - n0));
    chk("pos", 32'h2, {28'h0, pos_log[n0]});
    rc(ss(1, OFS_SS_FIFO), code(4'h1, 1'b1), "q3");
    slow <= 1'b0;
    wr(OFS_SAC, 32'h0);
    wr(OFS_ISC, 32'h2);
  endtask

  task automatic t_pri();
    int n0;
    n0 = pos_log.size();
    wr(OFS_PRI, 32'h3012);
    wr(ss(1, OFS_SS_CTL), 32'hA);
    wr(ss(2, OFS_SS_MUX), 32'h2);
    wr(ss(2, OFS_SS_CTL), 32'h2);
    wr(OFS_RUN, 32'h6);
    wr(OFS_PSSI, 32'h6);
    poll(ss(1, OFS_SS_FSTAT), 32'h100, 32'h0);
    chk("first", 32'h2, {28'h0, pos_log[n0]});
    rc(ss(2, OFS_SS_FIFO), code(4'h2, 1'b0), "q4");
    rc(ss(1, OFS_SS_FIFO), code(4'h1, 1'b0) | 32'h1, "q5");
  endtask

  task automatic pulse();
    @(posedge clk_sys);
    trig_in.timer <= 1'b1;
    repeat (4) @(posedge clk_sys);
    trig_in.timer <= 1'b0;
  endtask

  task automatic t_ovf();
    wr(OFS_EMUX, 32'h5000);
    wr(ss(3, OFS_SS_MUX), 32'h4);
    wr(ss(3, OFS_SS_CTL), 32'h2);
    wr(OFS_RUN, 32'h8);
    pulse();
    poll(ss(3, OFS_SS_FSTAT), 32'h1000, 32'h1000);
    pulse();
    poll(OFS_OSTAT, 32'hF, 32'h8);
    wr(OFS_OSTAT, 32'h8);
    rc(OFS_OSTAT, 32'h0, "ostat");
    rc(ss(3, OFS_SS_FIFO), code(4'h4, 1'b0), "q6");
    rd(ss(3, OFS_SS_FIFO));
    rc(OFS_USTAT, 32'h8, "ustat");
  endtask

  task automatic t_ce_rst();
    @(posedge clk_sys);
    ce <= 1'b0;
    reg_addr <= OFS_IM;
    reg_wdata <= 32'hF;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    ce <= 1'b1;
    rc(OFS_IM, 32'h0, "ce_im");
    @(posedge clk_sys);
    rst_b <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rst_b <= 1'b1;
    rc(OFS_PRI, {16'h0, RST_PRI}, "pri_rst");
    rc(OFS_RUN, 32'h0, "run_rst");
    chk("irq_rst", 32'h0, {31'h0, irq_r});
  endtask

  initial
  begin
    repeat (20) @(posedge clk_sys);
    rst_b <= 1'b1;
    rc(OFS_PRI, {16'h0, RST_PRI}, "pri");
    rc(OFS_SAC, 32'h0, "sac");
    rc(ss(0, OFS_SS_FSTAT), 32'h100, "fst");
    rc(12'hFFC, 32'h0, "unmapped");
    t_seq0();
    t_avg();
    t_pri();
    t_ovf();
    t_ce_rst();
    summarize();
  end
endmodule
